// file: design/crp_map.svh
// Decodes, bit positions and reset values of the card sense block
`ifndef CRP_MAP_SVH
`define CRP_MAP_SVH

// Aux-source decodes of move and branch microwords
`define CRP_AS_DATA_FIRST  4'hb
`define CRP_AS_DATA_SECOND 4'ha
`define CRP_AS_READER_COND 4'hd
`define CRP_AS_PUNCH_COND  4'hf
`define CRP_AS_DIAG_TENS   4'h8
`define CRP_AS_DIAG_UNITS  4'h9

// Reader condition bit positions
`define CRP_RD_NOT_COMPLETE 0
`define CRP_RD_READY        1
`define CRP_RD_UNIT_EXC     2
`define CRP_RD_CHECK        3
`define CRP_RD_VALIDITY     4
`define CRP_RD_DEV_END      5
`define CRP_RD_STATUS_REQ   6
`define CRP_RD_COMPAT_EXC   7

// Punch condition bit positions
`define CRP_PU_READY        0
`define CRP_PU_NOT_RUNIN    1
`define CRP_PU_UNIT_EXC     2
`define CRP_PU_CHECK        3
`define CRP_PU_VALIDITY     4
`define CRP_PU_DEV_END      5

// Diagnostic register fields
`define CRP_DG_ADDR_MSB     4
`define CRP_DG_ADDR_CHK     5
`define CRP_DG_OVERRUN      6
`define CRP_DG_SYNC_CHK     7

// Side index into per-side vectors
`define CRP_SIDE_READER     0
`define CRP_SIDE_PUNCH      1

// Reset values
`define CRP_BYTE_RST        8'h00
`define CRP_BIT_RST         1'h0

`endif

// file: design/crp_pkg.sv
// Types shared by the card sense block
package crp_pkg;

  typedef logic [7:0] crp_byte_t;

  typedef logic [3:0] crp_decode_t;

  typedef enum logic [1:0] {
    CRP_RUNIN_NONE,
    CRP_RUNIN_ONE,
    CRP_RUNIN_DONE
  } crp_runin_t;

endpackage

// file: design/crp_sense.sv
// Card reader/punch sense registers and branch conditions
`timescale 1ns/1ps
`include "crp_map.svh"

// Function
// R1 - While reading, first data register shifts bits from station 1 or feed-read brushes.
// R2 - Move microword with decode B copies first data register to auxiliary storage.
// R3 - Second data register shifts bits from station 2 or punch check brushes.
// R4 - Move microword with decode A copies second data register to auxiliary storage.
// R5 - Branch microword with decode D tests the reader condition byte.
// R6 - Reader bit 0 is zero when feed empty or card at station 2.
// R7 - Reader bit 1 shows ready; bit 2 shows feed run out with end-of-file.
// R8 - Reader bit 3 sets on hole-count, shift-register or address-check error.
// R9 - Reader bit 4 sets on multiple punches rows 1-7 in data mode 1.
// R10 - Bit 5 of both bytes sets device-end on overrun or ready rise.
// R11 - Reader bit 6 sets when channel-end or device-end status is pending.
// R12 - Reader bit 7 reads zero once last card passed station 2 with end-of-file.
// R13 - Branch microword with decode F tests the punch condition byte.
// R14 - Punch bit 0 reads one when the punch is ready.
// R15 - Punch bit 1 reads zero after a run-in of two feed cycles.
// R16 - Punch bit 2 reads one when last card passed punch station with end-of-file in punch feed-read mode.
// R17 - Punch bit 3 sets on hole-count, shift-register or address-check error.
// R18 - Punch bit 4 sets on multiple punches rows 1-7 at feed-read brushes.
// R19 - Decode 8 byte shows tens column address lines in bits 0-4.
// R20 - Decode 8 bits 5-7 flag punch address, overrun and sync checks in diagnostics.
// R21 - Decode 9 byte shows units column address lines in bits 0-4.
// R22 - Decode 9 bits 5-7 flag reader address, overrun and sync checks in diagnostics.
// R23 - Data registers are eight bits, one bit per scan impulse, read by move only.
module crp_sense (
  // Clock and reset
  input  wire logic               core_clk,
  input  wire logic               rst,
  // Microprogram move and branch requests
  input  wire crp_pkg::crp_decode_t aux_source_decode,
  input  wire logic               move_strobe,
  input  wire logic               branch_strobe,
  // Read station and brush sensing
  input  wire logic               card_reading,
  input  wire logic               station1_scan,
  input  wire logic               station1_bit,
  input  wire logic               punch_feed_read_scan,
  input  wire logic               punch_feed_read_bit,
  input  wire logic               station2_scan,
  input  wire logic               station2_bit,
  input  wire logic               punch_check_scan,
  input  wire logic               punch_check_bit,
  // Column row sensing for validity checks
  input  wire logic               reader_column_strobe,
  input  wire logic [6:0]         reader_rows_1_7,
  input  wire logic               data_mode_1,
  input  wire logic               punch_feed_read_column_strobe,
  input  wire logic [6:0]         punch_feed_read_rows_1_7,
  // Reader mechanism status
  input  wire logic               read_feed_empty,
  input  wire logic               card_at_station2,
  input  wire logic               reader_ready,
  input  wire logic               reader_end_of_file,
  input  wire logic               reader_channel_end,
  // Punch mechanism status
  input  wire logic               punch_ready,
  input  wire logic               punch_feed_cycle,
  input  wire logic               punch_feed_read_mode,
  input  wire logic               punch_end_of_file,
  input  wire logic               last_card_past_punch,
  // Per-side error events, index 0 reader, 1 punch
  input  wire logic [1:0]         hole_count_error,
  input  wire logic [1:0]         shift_reg_error,
  input  wire logic [1:0]         address_check_error,
  input  wire logic [1:0]         overrun,
  // Per-side clears from control latches
  input  wire logic [1:0]         check_clear,
  input  wire logic [1:0]         device_end_clear,
  // Diagnostic operation
  input  wire logic               diag_mode,
  input  wire logic               diag_clear,
  input  wire logic [4:0]         tens_column_address,
  input  wire logic [4:0]         units_column_address,
  // Answers to the microprogram
  output crp_pkg::crp_byte_t      aux_data,
  output logic                    move_done,
  output crp_pkg::crp_byte_t      branch_data,
  output logic                    branch_done
);

  crp_pkg::crp_byte_t  reader_data_in_first;
  crp_pkg::crp_byte_t  reader_data_in_second;
  crp_pkg::crp_byte_t  reader_branch_conditions;
  crp_pkg::crp_byte_t  punch_branch_conditions;
  crp_pkg::crp_byte_t  diag_tens_and_punch_checks;
  crp_pkg::crp_byte_t  diag_units_and_reader_checks;
  crp_pkg::crp_byte_t  next_aux_data;
  crp_pkg::crp_byte_t  next_branch_data;
  crp_pkg::crp_runin_t runin_state;

  logic [1:0] check_flag;
  logic [1:0] validity_flag;
  logic [1:0] validity_set;
  logic [1:0] hw_device_end;
  logic [1:0] ready_now;
  logic [1:0] ready_seen;
  logic [1:0] diag_addr_flag;
  logic [1:0] diag_overrun_flag;
  logic [1:0] diag_sync_flag;
  logic       reader_last_past;
  logic       punch_last_past;
  logic       station2_seen;
  logic       reader_multi;
  logic       punch_multi;

  // More than one of seven rows punched
  assign reader_multi = (reader_rows_1_7 & (reader_rows_1_7 - 7'h01)) != 7'h00;
  assign punch_multi  = (punch_feed_read_rows_1_7 & (punch_feed_read_rows_1_7 - 7'h01)) != 7'h00;

  // R9 reader validity source
  assign validity_set[`CRP_SIDE_READER] = reader_column_strobe & data_mode_1 & reader_multi;
  // R18 punch validity source
  assign validity_set[`CRP_SIDE_PUNCH] = punch_feed_read_column_strobe & punch_multi;

  assign ready_now[`CRP_SIDE_READER] = reader_ready;
  assign ready_now[`CRP_SIDE_PUNCH]  = punch_ready;

  // R1 first data shift
  always_ff @(posedge core_clk) begin
    if (rst) begin
      reader_data_in_first <= `CRP_BYTE_RST;
    end else if (card_reading && station1_scan) begin
      // R23 one bit per impulse
      reader_data_in_first <= {reader_data_in_first[6:0], station1_bit};
    end else if (card_reading && punch_feed_read_scan) begin
      reader_data_in_first <= {reader_data_in_first[6:0], punch_feed_read_bit};
    end
  end

  // R3 second data shift
  always_ff @(posedge core_clk) begin
    if (rst) begin
      reader_data_in_second <= `CRP_BYTE_RST;
    end else if (card_reading && station2_scan) begin
      reader_data_in_second <= {reader_data_in_second[6:0], station2_bit};
    end else if (card_reading && punch_check_scan) begin
      reader_data_in_second <= {reader_data_in_second[6:0], punch_check_bit};
    end
  end

  // Per-side sticky flags and ready history; in the flags, set wins over clear
  genvar s;
  generate
    for (s = 0; s < 2; s = s + 1) begin : g_side
      // R8 R17 check flags
      always_ff @(posedge core_clk) begin
        if (rst) begin
          check_flag[s] <= `CRP_BIT_RST;
        end else begin
          check_flag[s] <= hole_count_error[s] | shift_reg_error[s] | address_check_error[s]
                           | (check_flag[s] & ~check_clear[s]);
        end
      end

      // R9 R18 validity flags
      always_ff @(posedge core_clk) begin
        if (rst) begin
          validity_flag[s] <= `CRP_BIT_RST;
        end else begin
          validity_flag[s] <= validity_set[s] | (validity_flag[s] & ~check_clear[s]);
        end
      end

      // Ready history for edge detect
      always_ff @(posedge core_clk) begin
        if (rst) begin
          ready_seen[s] <= `CRP_BIT_RST;
        end else begin
          ready_seen[s] <= ready_now[s];
        end
      end

      // R10 hardware device-end
      always_ff @(posedge core_clk) begin
        if (rst) begin
          hw_device_end[s] <= `CRP_BIT_RST;
        end else begin
          hw_device_end[s] <= overrun[s] | (ready_now[s] & ~ready_seen[s])
                              | (hw_device_end[s] & ~device_end_clear[s]);
        end
      end

      // R20 R22 diagnostic checks
      always_ff @(posedge core_clk) begin
        if (rst) begin
          diag_addr_flag[s]    <= `CRP_BIT_RST;
          diag_overrun_flag[s] <= `CRP_BIT_RST;
          diag_sync_flag[s]    <= `CRP_BIT_RST;
        end else begin
          diag_addr_flag[s]    <= (diag_mode & address_check_error[s])
                                  | (diag_addr_flag[s] & ~diag_clear);
          diag_overrun_flag[s] <= (diag_mode & overrun[s])
                                  | (diag_overrun_flag[s] & ~diag_clear);
          diag_sync_flag[s]    <= (diag_mode & shift_reg_error[s])
                                  | (diag_sync_flag[s] & ~diag_clear);
        end
      end
    end
  endgenerate

  // Station 2 history for trailing edge
  always_ff @(posedge core_clk) begin
    if (rst) begin
      station2_seen <= `CRP_BIT_RST;
    end else begin
      station2_seen <= card_at_station2;
    end
  end

  // R12 last card past station 2
  always_ff @(posedge core_clk) begin
    if (rst) begin
      reader_last_past <= `CRP_BIT_RST;
    end else if (!reader_end_of_file) begin
      reader_last_past <= `CRP_BIT_RST;
    end else if (station2_seen && !card_at_station2 && read_feed_empty) begin
      reader_last_past <= 1'h1;
    end
  end

  // R16 last card past punch station
  always_ff @(posedge core_clk) begin
    if (rst) begin
      punch_last_past <= `CRP_BIT_RST;
    end else if (!punch_end_of_file || !punch_feed_read_mode) begin
      punch_last_past <= `CRP_BIT_RST;
    end else if (last_card_past_punch) begin
      punch_last_past <= 1'h1;
    end
  end

  // R15 run-in of two feed cycles
  always_ff @(posedge core_clk) begin
    if (rst) begin
      runin_state <= crp_pkg::CRP_RUNIN_NONE;
    end else if (ready_seen[`CRP_SIDE_PUNCH] && !punch_ready) begin
      runin_state <= crp_pkg::CRP_RUNIN_NONE;
    end else if (punch_feed_cycle) begin
      unique case (runin_state)
        crp_pkg::CRP_RUNIN_NONE: begin
          runin_state <= crp_pkg::CRP_RUNIN_ONE;
        end
        crp_pkg::CRP_RUNIN_ONE: begin
          runin_state <= crp_pkg::CRP_RUNIN_DONE;
        end
        crp_pkg::CRP_RUNIN_DONE: begin
          runin_state <= crp_pkg::CRP_RUNIN_DONE;
        end
      endcase
    end
  end

  // Reader condition byte
  always_comb begin
    reader_branch_conditions = `CRP_BYTE_RST;
    // R6 not read complete
    reader_branch_conditions[`CRP_RD_NOT_COMPLETE] = ~(read_feed_empty | card_at_station2);
    // R7 ready and unit exception
    reader_branch_conditions[`CRP_RD_READY]    = reader_ready;
    reader_branch_conditions[`CRP_RD_UNIT_EXC] = read_feed_empty & ~card_at_station2
                                                 & reader_end_of_file;
    reader_branch_conditions[`CRP_RD_CHECK]    = check_flag[`CRP_SIDE_READER];
    reader_branch_conditions[`CRP_RD_VALIDITY] = validity_flag[`CRP_SIDE_READER];
    reader_branch_conditions[`CRP_RD_DEV_END]  = hw_device_end[`CRP_SIDE_READER];
    // R11 status request
    reader_branch_conditions[`CRP_RD_STATUS_REQ] = reader_channel_end
                                                   | hw_device_end[`CRP_SIDE_READER];
    // R12 compatibility exception
    reader_branch_conditions[`CRP_RD_COMPAT_EXC] = ~reader_last_past;
  end

  // Punch condition byte
  always_comb begin
    punch_branch_conditions = `CRP_BYTE_RST;
    // R14 punch ready
    punch_branch_conditions[`CRP_PU_READY]     = punch_ready;
    punch_branch_conditions[`CRP_PU_NOT_RUNIN] = runin_state != crp_pkg::CRP_RUNIN_DONE;
    punch_branch_conditions[`CRP_PU_UNIT_EXC]  = punch_last_past;
    punch_branch_conditions[`CRP_PU_CHECK]     = check_flag[`CRP_SIDE_PUNCH];
    punch_branch_conditions[`CRP_PU_VALIDITY]  = validity_flag[`CRP_SIDE_PUNCH];
    punch_branch_conditions[`CRP_PU_DEV_END]   = hw_device_end[`CRP_SIDE_PUNCH];
  end

  // Diagnostic bytes
  always_comb begin
    // R19 tens address
    diag_tens_and_punch_checks[`CRP_DG_ADDR_MSB:0] = tens_column_address;
    diag_tens_and_punch_checks[`CRP_DG_ADDR_CHK]   = diag_addr_flag[`CRP_SIDE_PUNCH];
    diag_tens_and_punch_checks[`CRP_DG_OVERRUN]    = diag_overrun_flag[`CRP_SIDE_PUNCH];
    diag_tens_and_punch_checks[`CRP_DG_SYNC_CHK]   = diag_sync_flag[`CRP_SIDE_PUNCH];
    // R21 units address
    diag_units_and_reader_checks[`CRP_DG_ADDR_MSB:0] = units_column_address;
    diag_units_and_reader_checks[`CRP_DG_ADDR_CHK]   = diag_addr_flag[`CRP_SIDE_READER];
    diag_units_and_reader_checks[`CRP_DG_OVERRUN]    = diag_overrun_flag[`CRP_SIDE_READER];
    diag_units_and_reader_checks[`CRP_DG_SYNC_CHK]   = diag_sync_flag[`CRP_SIDE_READER];
  end

  // Move source select
  always_comb begin
    next_aux_data = `CRP_BYTE_RST;
    unique case (aux_source_decode)
      // R2 move first register
      `CRP_AS_DATA_FIRST: begin
        next_aux_data = reader_data_in_first;
      end
      // R4 move second register
      `CRP_AS_DATA_SECOND: begin
        next_aux_data = reader_data_in_second;
      end
      default: begin
        next_aux_data = `CRP_BYTE_RST;
      end
    endcase
  end

  // Branch source select
  always_comb begin
    next_branch_data = `CRP_BYTE_RST;
    unique case (aux_source_decode)
      // R5 reader conditions
      `CRP_AS_READER_COND: begin
        next_branch_data = reader_branch_conditions;
      end
      // R13 punch conditions
      `CRP_AS_PUNCH_COND: begin
        next_branch_data = punch_branch_conditions;
      end
      `CRP_AS_DIAG_TENS: begin
        next_branch_data = diag_tens_and_punch_checks;
      end
      `CRP_AS_DIAG_UNITS: begin
        next_branch_data = diag_units_and_reader_checks;
      end
      default: begin
        next_branch_data = `CRP_BYTE_RST;
      end
    endcase
  end

  // Move answer
  always_ff @(posedge core_clk) begin
    if (rst) begin
      aux_data  <= `CRP_BYTE_RST;
      move_done <= `CRP_BIT_RST;
    end else begin
      move_done <= move_strobe;
      if (move_strobe) begin
        aux_data <= next_aux_data;
      end
    end
  end

  // Branch answer
  always_ff @(posedge core_clk) begin
    if (rst) begin
      branch_data <= `CRP_BYTE_RST;
      branch_done <= `CRP_BIT_RST;
    end else begin
      branch_done <= branch_strobe;
      if (branch_strobe) begin
        branch_data <= next_branch_data;
      end
    end
  end

endmodule

// file: testbench/card_reader_punch_sense_tb.sv
// Self-checking bench of the card sense block
`timescale 1ns/1ps
module card_reader_punch_sense_tb;
  logic                 core_clk, rst, move_strobe, branch_strobe, data_mode_1, diag_mode, diag_clear;
  crp_pkg::crp_decode_t aux_source_decode;
  logic                 card_reading, station1_scan, station1_bit, punch_feed_read_scan, punch_feed_read_bit;
  logic                 station2_scan, station2_bit, punch_check_scan, punch_check_bit;
  logic                 reader_column_strobe, punch_feed_read_column_strobe;
  logic [6:0]           reader_rows_1_7, punch_feed_read_rows_1_7;
  logic                 read_feed_empty, card_at_station2, reader_ready, reader_end_of_file, reader_channel_end;
  logic                 punch_ready, punch_feed_cycle, punch_feed_read_mode, punch_end_of_file, last_card_past_punch;
  logic [1:0]           hole_count_error, shift_reg_error, address_check_error, overrun, check_clear, device_end_clear;
  logic [4:0]           tens_column_address, units_column_address;
  crp_pkg::crp_byte_t   aux_data, branch_data;
  logic                 move_done, branch_done;
  int                   fails, comparisons;

  initial core_clk = 1'b0;
  always #4 core_clk = ~core_clk;

  crp_sense dut (.core_clk, .rst, .aux_source_decode, .move_strobe, .branch_strobe, .card_reading, .station1_scan,
    .station1_bit, .punch_feed_read_scan, .punch_feed_read_bit, .station2_scan, .station2_bit, .punch_check_scan,
    .punch_check_bit, .reader_column_strobe, .reader_rows_1_7, .data_mode_1, .punch_feed_read_column_strobe,
    .punch_feed_read_rows_1_7, .read_feed_empty, .card_at_station2, .reader_ready, .reader_end_of_file,
    .reader_channel_end, .punch_ready, .punch_feed_cycle, .punch_feed_read_mode, .punch_end_of_file,
    .last_card_past_punch, .hole_count_error, .shift_reg_error, .address_check_error, .overrun, .check_clear,
    .device_end_clear, .diag_mode, .diag_clear, .tens_column_address, .units_column_address, .aux_data,
    .move_done, .branch_data, .branch_done);

  crp_mech_model u_mech (.core_clk, .card_reading, .station1_scan, .station1_bit, .punch_feed_read_scan,
    .punch_feed_read_bit, .station2_scan, .station2_bit, .punch_check_scan, .punch_check_bit);

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Move or branch microword, answer one cycle after it is taken
  task automatic req(input logic mv, input logic [3:0] dec, input logic [7:0] exp);
    @(posedge core_clk);
    aux_source_decode <= dec;
    {move_strobe, branch_strobe} <= mv ? 2'b10 : 2'b01;
    @(posedge core_clk);
    {move_strobe, branch_strobe} <= 2'b00;
    #1;
    check("done", {7'h00, mv ? move_done : branch_done}, 8'h01);
    check(mv ? "aux_data" : "branch_data", mv ? aux_data : branch_data, exp);
  endtask

  task automatic err(input logic [7:0] v);
    @(posedge core_clk) {overrun, address_check_error, shift_reg_error, hole_count_error} <= v;
    @(posedge core_clk) {overrun, address_check_error, shift_reg_error, hole_count_error} <= 8'h00;
  endtask

  task automatic clr(input logic [3:0] v);
    @(posedge core_clk) {device_end_clear, check_clear} <= v;
    @(posedge core_clk) {device_end_clear, check_clear} <= 4'h0;
  endtask

  task automatic rows(input logic punch, input logic [6:0] r);
    @(posedge core_clk);
    {reader_rows_1_7, punch_feed_read_rows_1_7} <= {r, r};
    {punch_feed_read_column_strobe, reader_column_strobe} <= {punch, !punch};
    @(posedge core_clk) {punch_feed_read_column_strobe, reader_column_strobe} <= 2'b00;
  endtask

  task automatic summarize();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge core_clk);
    fails++;
    summarize();
  end

  initial begin
    {fails, comparisons} = '0;
    rst = 1'b1;
    {move_strobe, branch_strobe, aux_source_decode, data_mode_1, diag_mode, diag_clear} = '0;
    {reader_column_strobe, punch_feed_read_column_strobe, reader_rows_1_7, punch_feed_read_rows_1_7} = '0;
    {read_feed_empty, card_at_station2, reader_ready, reader_end_of_file, reader_channel_end} = '0;
    {punch_ready, punch_feed_cycle, punch_feed_read_mode, punch_end_of_file, last_card_past_punch} = '0;
    {hole_count_error, shift_reg_error, address_check_error, overrun, check_clear, device_end_clear} = '0;
    {tens_column_address, units_column_address} = '0;
    repeat (8) @(posedge core_clk);
    rst <= 1'b0;
    u_mech.read_card(8'hc5, 8'h3a, 1'b0, 0);
    req(1'b1, 4'hb, 8'hc5);
    req(1'b1, 4'ha, 8'h3a);
    u_mech.read_card(8'h96, 8'h69, 1'b1, 3);
    req(1'b1, 4'hb, 8'h96);
    req(1'b1, 4'ha, 8'h69);
    req(1'b1, 4'h0, 8'h00);
    $display("test moves done");
    @(posedge core_clk) reader_ready <= 1'b1;
    repeat (3) @(posedge core_clk);
    req(1'b0, 4'hd, 8'he3);
    clr(4'h4);
    req(1'b0, 4'hd, 8'h83);
    @(posedge core_clk) {reader_channel_end, read_feed_empty, reader_end_of_file, card_at_station2} <= 4'h8;
    req(1'b0, 4'hd, 8'hc3);
    @(posedge core_clk) {reader_channel_end, read_feed_empty, reader_end_of_file, card_at_station2} <= 4'h7;
    req(1'b0, 4'hd, 8'h82);
    @(posedge core_clk) card_at_station2 <= 1'b0;
    @(posedge core_clk);
    req(1'b0, 4'hd, 8'h06);
    @(posedge core_clk) {read_feed_empty, reader_end_of_file} <= 2'b00;
    req(1'b0, 4'hd, 8'h83);
    for (int k = 0; k < 3; k++) begin
      err(8'h01 << (2 * k));
      req(1'b0, 4'hd, 8'h8b);
      clr(4'h1);
      req(1'b0, 4'hd, 8'h83);
    end
    @(posedge core_clk) {check_clear, hole_count_error} <= 4'h5;
    @(posedge core_clk) {check_clear, hole_count_error} <= 4'h0;
    req(1'b0, 4'hd, 8'h8b);
    clr(4'h1);
    rows(1'b0, 7'h41);
    req(1'b0, 4'hd, 8'h83);
    @(posedge core_clk) data_mode_1 <= 1'b1;
    rows(1'b0, 7'h08);
    req(1'b0, 4'hd, 8'h83);
    rows(1'b0, 7'h41);
    req(1'b0, 4'hd, 8'h93);
    clr(4'h1);
    err(8'h40);
    req(1'b0, 4'hd, 8'he3);
    clr(4'h4);
    $display("test reader done");
    @(posedge core_clk) punch_ready <= 1'b1;
    repeat (3) @(posedge core_clk);
    req(1'b0, 4'hf, 8'h23);
    clr(4'h8);
    repeat (2) begin
      @(posedge core_clk) punch_feed_cycle <= 1'b1;
      @(posedge core_clk) punch_feed_cycle <= 1'b0;
    end
    req(1'b0, 4'hf, 8'h01);
    for (int k = 0; k < 3; k++) begin
      err(8'h02 << (2 * k));
      req(1'b0, 4'hf, 8'h09);
      clr(4'h2);
    end
    rows(1'b1, 7'h03);
    req(1'b0, 4'hf, 8'h11);
    clr(4'h2);
    @(posedge core_clk) {punch_feed_read_mode, punch_end_of_file, last_card_past_punch} <= 3'h7;
    @(posedge core_clk) last_card_past_punch <= 1'b0;
    req(1'b0, 4'hf, 8'h05);
    @(posedge core_clk) {punch_feed_read_mode, punch_end_of_file} <= 2'b00;
    req(1'b0, 4'hf, 8'h01);
    $display("test punch done");
    err(8'haa);
    req(1'b0, 4'h8, 8'h00);
    @(posedge core_clk) {diag_mode, tens_column_address, units_column_address} <= {1'b1, 5'h15, 5'h0a};
    err(8'haa);
    err(8'h55);
    req(1'b0, 4'h8, 8'hf5);
    req(1'b0, 4'h9, 8'hea);
    @(posedge core_clk) diag_clear <= 1'b1;
    @(posedge core_clk) diag_clear <= 1'b0;
    req(1'b0, 4'h9, 8'h0a);
    req(1'b0, 4'h0, 8'h00);
    $display("test diagnostics done");
    summarize();
  end
endmodule

// file: testbench/crp_mech_model.sv
// Reader/punch mechanism driving the scan and sense lines
`timescale 1ns/1ps
module crp_mech_model (
  // Clock
  input  wire logic core_clk,
  // Brush and station sense lines
  output logic      card_reading,
  output logic      station1_scan,
  output logic      station1_bit,
  output logic      punch_feed_read_scan,
  output logic      punch_feed_read_bit,
  output logic      station2_scan,
  output logic      station2_bit,
  output logic      punch_check_scan,
  output logic      punch_check_bit
);
  initial begin
    {card_reading, station1_scan, punch_feed_read_scan, station2_scan, punch_check_scan} = 5'h00;
    {station1_bit, punch_feed_read_bit, station2_bit, punch_check_bit} = 4'h0;
  end

  // One card, eight columns, msb first; brushes or stations
  task automatic read_card(input logic [7:0] first, input logic [7:0] second, input logic brushes, input int gap);
    @(posedge core_clk);
    card_reading <= 1'b1;
    for (int i = 7; i >= 0; i--) begin
      {station1_scan, station2_scan} <= {2{!brushes}};
      {punch_feed_read_scan, punch_check_scan} <= {2{brushes}};
      {station1_bit, punch_feed_read_bit} <= {2{first[i]}};
      {station2_bit, punch_check_bit} <= {2{second[i]}};
      @(posedge core_clk);
      {station1_scan, station2_scan, punch_feed_read_scan, punch_check_scan} <= 4'h0;
      {station1_bit, punch_feed_read_bit} <= {2{!first[i]}};
      {station2_bit, punch_check_bit} <= {2{!second[i]}};
      repeat (gap + 1) @(posedge core_clk);
    end
    card_reading <= 1'b0;
  endtask
endmodule

// file: testbench/crp_sense_assertions.sv
// Port assertions of the card sense block
`timescale 1ns/1ps
module crp_sense_assertions (
  // Clock and reset
  input wire logic                 core_clk,
  input wire logic                 rst,
  // Requests
  input wire crp_pkg::crp_decode_t aux_source_decode,
  input wire logic                 move_strobe,
  input wire logic                 branch_strobe,
  // Sensed levels and events
  input wire logic                 read_feed_empty,
  input wire logic                 card_at_station2,
  input wire logic                 reader_ready,
  input wire logic                 punch_ready,
  input wire logic [1:0]           hole_count_error,
  input wire logic [4:0]           tens_column_address,
  input wire logic [4:0]           units_column_address,
  // Answers
  input wire crp_pkg::crp_byte_t   aux_data,
  input wire logic                 move_done,
  input wire crp_pkg::crp_byte_t   branch_data,
  input wire logic                 branch_done
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  sequence br_on(d);
    branch_strobe && aux_source_decode == d;
  endsequence
  sequence hole_then_test;
    hole_count_error[0] ##[1:3] br_on(4'hd);
  endsequence

  a_move_done_pulse: assert property (move_strobe |=> move_done)
    else $error("move_done missing after move");
  a_move_no_spurious: assert property (!move_strobe |=> !move_done)
    else $error("move_done without move");
  a_move_other_zero: assert property (move_strobe && !(aux_source_decode inside {4'ha, 4'hb}) |=> aux_data == 8'h00)
    else $error("aux_data nonzero for other decode");
  a_aux_hold_value: assert property (!move_strobe |=> $stable(aux_data))
    else $error("aux_data changed without move");
  a_branch_done_pulse: assert property (branch_strobe |=> branch_done)
    else $error("branch_done missing after branch");
  a_reader_ready_bit: assert property (br_on(4'hd) |=> branch_data[1] == $past(reader_ready))
    else $error("reader ready bit wrong");
  a_not_complete_bit: assert property (br_on(4'hd) |=> branch_data[0] == !($past(read_feed_empty) || $past(card_at_station2)))
    else $error("reader not complete bit wrong");
  a_punch_ready_bit: assert property (br_on(4'hf) |=> branch_data[0] == $past(punch_ready))
    else $error("punch ready bit wrong");
  a_tens_address: assert property (br_on(4'h8) |=> branch_data[4:0] == $past(tens_column_address))
    else $error("tens address field wrong");
  a_units_address: assert property (br_on(4'h9) |=> branch_data[4:0] == $past(units_column_address))
    else $error("units address field wrong");
  a_reader_check_set: assert property (hole_then_test |=> branch_data[3])
    else $error("reader check bit not set");
endmodule

bind crp_sense crp_sense_assertions u_chk (.core_clk, .rst, .aux_source_decode, .move_strobe, .branch_strobe,
  .read_feed_empty, .card_at_station2, .reader_ready, .punch_ready, .hole_count_error, .tens_column_address,
  .units_column_address, .aux_data, .move_done, .branch_data, .branch_done);
